// ---- sgc_regs.svh ----
// Offsets, field positions, reset values and timing counts of global control one
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH
`define SGC_GC1_OFFSET 8'h03
`define SGC_BIT_PASS_ALL 7
`define SGC_BIT_RSVD 6
`define SGC_BIT_TX_FC_DIS 5
`define SGC_BIT_RX_FC_DIS 4
`define SGC_BIT_LEN_CHECK 3
`define SGC_BIT_AGING_EN 2
`define SGC_BIT_FAST_AGE 1
`define SGC_BIT_AGGR_BACKOFF 0
`define SGC_RESET_FIXED 8'h00
`define SGC_LEN_CHECK_LIMIT 16'h05DC
`define SGC_CLK_HZ 200000000
`define SGC_FAST_AGE_US 800
`define SGC_NORMAL_AGE_S 300
`define SGC_NORMAL_AGE_EXTRA_S 75
`define SGC_FAST_AGE_CYCLES ((`SGC_CLK_HZ / 1000000) * `SGC_FAST_AGE_US)
`define SGC_NORMAL_AGE_CYCLES_64 (64'd200000000 * 64'd300)
`endif

// ---- sgc_pkg.sv ----
// Types shared by the global control one block
package sgc_pkg;
  typedef struct packed {
    logic pass_all;
    logic rsvd;
    logic tx_fc_dis;
    logic rx_fc_dis;
    logic len_check;
    logic aging_en;
    logic fast_age;
    logic aggr_backoff;
  } sgc_ctrl_t;

  typedef struct packed {
    logic [1:0] flow_ctrl_s;
    logic [1:0] aging_s;
    logic [1:0] backoff_s;
  } sgc_strap_sync_t;

  typedef enum logic [0:0] {SGC_AGE_IDLE, SGC_AGE_COUNT} sgc_age_state_t;
endpackage

// ---- sgc_age_timer.sv ----
// Aging interval timer that pulses once per age period
`timescale 1ns/10ps
`include "sgc_regs.svh"
module sgc_age_timer #(
  parameter logic [63:0] NORMAL_CYCLES = 64'd60000000000,
  parameter logic [63:0] EXTRA_CYCLES = 64'd15000000000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic fast,
  output logic age_tick
);
  typedef struct packed {
    sgc_pkg::sgc_age_state_t st;
    logic [63:0] cnt;
    logic tick;
  } sgc_timer_state_t;

  sgc_timer_state_t s_q;
  sgc_timer_state_t s_d;
  logic [63:0] limit;

  // Fast interval or normal 300 plus 75 seconds
  always_comb begin
    if (fast) begin
      limit = 64'(`SGC_FAST_AGE_CYCLES); // see [RL8]
    end else begin
      limit = NORMAL_CYCLES + EXTRA_CYCLES; // see [RL10]
    end
  end

  // Count while aging is enabled; stop and clear when disabled
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    unique case (s_q.st)
      sgc_pkg::SGC_AGE_IDLE: begin
        s_d.cnt = 64'h0;
        if (enable) begin
          s_d.st = sgc_pkg::SGC_AGE_COUNT;
        end
      end
      sgc_pkg::SGC_AGE_COUNT: begin
        if (!enable) begin
          s_d.st = sgc_pkg::SGC_AGE_IDLE; // see [RL6]
          s_d.cnt = 64'h0;
        end else if (s_q.cnt >= limit - 64'h1) begin
          s_d.cnt = 64'h0;
          s_d.tick = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 64'h1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{st: sgc_pkg::SGC_AGE_IDLE, cnt: 64'h0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign age_tick = s_q.tick;
endmodule // sgc_age_timer

// ---- sgc_global_control_one.sv ----
// Global control one register with strap defaults and derived enables
`timescale 1ns/10ps
`include "sgc_regs.svh"

// Behaviour
// [RL1] Bit 7 set makes the switch forward every frame, errored ones too, for debug.
// [RL2] Bit 5 clear lets transmit pause follow negotiation; set forces it off.
// [RL3] Bit 4 clear lets receive pause follow negotiation; set forces it off.
// [RL4] Bits 5 and 4 reset from one pulled-down strap, then are written separately.
// [RL5] Bit 3 set drops frames whose length field under 1500 mismatches the true length.
// [RL6] Bit 2 enables address aging; clear stops aging entirely.
// [RL7] The aging enable resets from a pulled-up strap; low disables aging.
// [RL8] Bit 1 selects a fast age interval of about 800 us and resets to zero.
// [RL9] Bit 0 enables aggressive half-duplex back-off, reset from a pulled-down strap.
// [RL10] With fast aging off the age period is 300 plus 75 seconds.
// [RL11] Bit 6 is reserved, reads back what was written, resets to zero, does nothing.
module sgc_global_control_one (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flow_ctrl_strap_pin,
  input wire logic aging_strap_pin,
  input wire logic backoff_strap_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic an_tx_pause,
  input wire logic an_rx_pause,
  input wire logic rx_frame_valid,
  input wire logic rx_frame_err,
  input wire logic [15:0] rx_len_field,
  input wire logic [15:0] rx_actual_len,
  output logic tx_fc_en,
  output logic rx_fc_en,
  output logic pass_all_frames,
  output logic frame_accept,
  output logic frame_drop,
  output logic aging_en,
  output logic fast_age_en,
  output logic age_tick,
  output logic aggr_backoff_en
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sgc_pkg::sgc_strap_sync_t sync;
    logic strap_pending;
    sgc_pkg::sgc_ctrl_t ctrl;
    logic [7:0] rdata;
    logic rvalid;
    logic tx_fc;
    logic rx_fc;
    logic accept;
    logic drop;
    logic tick;
  } sgc_state_t;

  sgc_state_t s_q;
  sgc_state_t s_d;
  logic timer_tick;
  logic len_mismatch;

  // Length field check applies only to length-coded frames under 1500
  function automatic logic len_bad(input logic [15:0] field, input logic [15:0] actual);
    len_bad = (field < `SGC_LEN_CHECK_LIMIT) && (field != actual);
  endfunction

  assign len_mismatch = len_bad(rx_len_field, rx_actual_len);

  ////////////////////////////////////////////////////////////////////////////
  // Age interval timer
  sgc_age_timer #(
    .NORMAL_CYCLES(`SGC_NORMAL_AGE_CYCLES_64),
    .EXTRA_CYCLES(64'd200000000 * 64'd75)
  ) u_age_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(s_q.ctrl.aging_en), // see [RL6]
    .fast(s_q.ctrl.fast_age), // see [RL8]
    .age_tick(timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: strap sync, strap load, register access, derived enables
  always_comb begin
    s_d = s_q;
    s_d.sync.flow_ctrl_s = {s_q.sync.flow_ctrl_s[0], flow_ctrl_strap_pin};
    s_d.sync.aging_s = {s_q.sync.aging_s[0], aging_strap_pin};
    s_d.sync.backoff_s = {s_q.sync.backoff_s[0], backoff_strap_pin};
    s_d.rvalid = 1'b0;
    s_d.accept = 1'b0;
    s_d.drop = 1'b0;
    s_d.tick = timer_tick;
    if (s_q.strap_pending) begin
      // Straps latched once after release, after passing the synchroniser
      s_d.strap_pending = 1'b0;
      s_d.ctrl.tx_fc_dis = s_q.sync.flow_ctrl_s[1]; // see [RL4]
      s_d.ctrl.rx_fc_dis = s_q.sync.flow_ctrl_s[1]; // see [RL4]
      s_d.ctrl.aging_en = s_q.sync.aging_s[1]; // see [RL7]
      s_d.ctrl.aggr_backoff = s_q.sync.backoff_s[1]; // see [RL9]
    end else if (reg_wr && reg_addr == `SGC_GC1_OFFSET) begin
      s_d.ctrl = sgc_pkg::sgc_ctrl_t'(reg_wdata); // see [RL11]
    end
    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = (reg_addr == `SGC_GC1_OFFSET) ? 8'(s_q.ctrl) : 8'h00;
    end
    // Pause enables gated by negotiation result
    s_d.tx_fc = an_tx_pause && !s_q.ctrl.tx_fc_dis; // see [RL2]
    s_d.rx_fc = an_rx_pause && !s_q.ctrl.rx_fc_dis; // see [RL3]
    // Frame filter decision
    if (rx_frame_valid) begin
      if (s_q.ctrl.pass_all) begin
        s_d.accept = 1'b1; // see [RL1]
      end else if (rx_frame_err || (s_q.ctrl.len_check && len_mismatch)) begin
        s_d.drop = 1'b1; // see [RL5]
      end else begin
        s_d.accept = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      // Keep the strap synchroniser running so the load after release sees the pins
      s_q.sync <= s_d.sync; // see [RL4]
      s_q.strap_pending <= 1'b1;
      s_q.ctrl <= sgc_pkg::sgc_ctrl_t'(`SGC_RESET_FIXED); // see [RL8]
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign tx_fc_en = s_q.tx_fc;
  assign rx_fc_en = s_q.rx_fc;
  assign pass_all_frames = s_q.ctrl.pass_all;
  assign frame_accept = s_q.accept;
  assign frame_drop = s_q.drop;
  assign aging_en = s_q.ctrl.aging_en;
  assign fast_age_en = s_q.ctrl.fast_age;
  assign age_tick = s_q.tick;
  assign aggr_backoff_en = s_q.ctrl.aggr_backoff;
endmodule // sgc_global_control_one

// ---- sgc_gc1_chk.sv ----
// Assertion checker for the global control one block
`timescale 1ns/10ps
module sgc_gc1_chk (
  input logic ref_clk, rst, reg_rd, reg_rvalid, an_tx_pause, an_rx_pause, tx_fc_en,
  input logic rx_fc_en, rx_frame_valid, rx_frame_err, pass_all_frames, frame_accept,
  input logic frame_drop, aging_en, age_tick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Pause, filter, aging and read relations
  chk_tx_pause_gate: assert property (!$past(an_tx_pause) |-> !tx_fc_en)
    else $error("tx pause");
  chk_rx_pause_gate: assert property (!$past(an_rx_pause) |-> !rx_fc_en)
    else $error("rx pause");
  chk_pass_all_fwd: assert property (rx_frame_valid && pass_all_frames
    |=> frame_accept && !frame_drop) else $error("pass all");
  chk_err_drop: assert property (rx_frame_valid && rx_frame_err && !pass_all_frames
    |=> frame_drop) else $error("bad frame");
  chk_verdict_cause: assert property (frame_accept || frame_drop |-> $past(rx_frame_valid))
    else $error("no frame");
  chk_one_verdict: assert property (!(frame_accept && frame_drop))
    else $error("two verdicts");
  chk_age_gate: assert property (age_tick |-> $past(aging_en))
    else $error("age off");
  chk_read_answer: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid)
    else $error("read answer");
  // Main scenarios
  cover property (frame_drop);
  cover property (frame_accept && pass_all_frames);
  cover property (tx_fc_en && rx_fc_en);
endmodule // sgc_gc1_chk
////////////////////////////////////////
bind sgc_global_control_one sgc_gc1_chk i_chk (.*);

// ---- switch_global_control_one_tb.sv ----
// Testbench for the global control one block
`timescale 1ns/10ps
module switch_global_control_one_tb;
  logic ref_clk, rst, flow_ctrl_strap_pin, aging_strap_pin, backoff_strap_pin, reg_wr, reg_rd;
  logic an_tx_pause, an_rx_pause, rx_frame_valid, rx_frame_err, reg_rvalid, tx_fc_en, rx_fc_en;
  logic pass_all_frames, frame_accept, frame_drop, aging_en, fast_age_en, age_tick;
  logic aggr_backoff_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] rx_len_field, rx_actual_len;
  int fail_count, compares, cyc;
  sgc_global_control_one i_dut (.*);
  // Clock
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register access; a read compares against d
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge ref_clk);
    #1 {reg_wr, reg_rd} = 2'h0;
    if (!w) chk("rdata", d, reg_rdata);
    if (!w) chk("rvalid", 8'h01, {7'h00, reg_rvalid});
  endtask
  // One frame; d is the expected drop
  task automatic frm(logic e, logic [15:0] l, logic [15:0] a, logic d);
    @(posedge ref_clk);
    #1 {rx_frame_valid, rx_frame_err, rx_len_field, rx_actual_len} = {1'h1, e, l, a};
    @(posedge ref_clk);
    #1 rx_frame_valid = 0;
    chk("filter", {6'h00, !d, d}, {6'h00, frame_accept, frame_drop});
  endtask
  // Let registered levels land
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // Closing report
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, reg_wr, reg_rd, rx_frame_valid, rx_frame_err, an_tx_pause, an_rx_pause} = 7'h40;
    {flow_ctrl_strap_pin, aging_strap_pin, backoff_strap_pin, reg_addr, reg_wdata} = '0;
    {rx_len_field, rx_actual_len} = '0;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      #1 rst = 1;
      {flow_ctrl_strap_pin, aging_strap_pin, backoff_strap_pin} = i ? 3'h2 : 3'h5;
      repeat (8) @(posedge ref_clk);
      #1 rst = 0;
      repeat (2) @(posedge ref_clk);
      bus(0, 8'h03, i ? 8'h04 : 8'h31);
      settle;
      chk("straps", i ? 8'h02 : 8'h01, {6'h00, aging_en, aggr_backoff_en});
      $display("test strap %0d done", i);
    end
    bus(1, 8'h03, 8'h40);
    bus(1, 8'h05, 8'hFF);
    bus(0, 8'h03, 8'h40);
    bus(0, 8'h05, 8'h00);
    $display("test access done");
    {an_tx_pause, an_rx_pause} = 2'h3;
    for (int d = 0; d < 4; d++) begin
      bus(1, 8'h03, 8'(d << 4));
      settle;
      chk("pause", 8'(3 - d), {6'h00, tx_fc_en, rx_fc_en});
    end
    $display("test pause done");
    bus(1, 8'h03, 8'h08);
    settle;
    frm(1'h0, 16'h64, 16'h64, 1'h0);
    frm(1'h0, 16'h64, 16'h63, 1'h1);
    frm(1'h0, 16'h5DC, 16'h63, 1'h0);
    frm(1'h1, 16'h64, 16'h64, 1'h1);
    bus(1, 8'h03, 8'h80);
    settle;
    frm(1'h1, 16'h64, 16'h63, 1'h0);
    bus(1, 8'h03, 8'h06);
    settle;
    frm(1'h0, 16'h64, 16'h63, 1'h0);
    chk("aging", 8'h03, {6'h00, aging_en, fast_age_en});
    $display("test frames done");
    test_done();
  end
endmodule // switch_global_control_one_tb
